// File: core/ctf_defines.svh
// Offsets, field positions, reset values and widths of the transmit flag block
// Assumes a byte-wide register port with an 8-bit address
`ifndef CTF_DEFINES_SVH
`define CTF_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CTF_ADDR_W 8
`define CTF_DATA_W 8
`define CTF_OFF_CONTROL 8'h00
`define CTF_OFF_RX_FLAGS 8'h04
`define CTF_OFF_RX_IE 8'h05
`define CTF_OFF_TX_FLAGS 8'h06
`define CTF_OFF_TX_IE 8'h07
`define CTF_OFF_ABORT_REQ 8'h08
`define CTF_OFF_ABORT_ACK 8'h09

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTF_CTL_INIT_REQ 0
`define CTF_CTL_LISTEN 1
`define CTF_CTL_WAKE_FN 2
`define CTF_CTL_INIT_ACK 3
`define CTF_RXF_FULL 0
`define CTF_RXF_OVERRUN 1
`define CTF_RXF_STATE_LO 4
`define CTF_RIE_RX_FULL 0
`define CTF_RIE_OVERRUN 1
`define CTF_RIE_WAKE 7
`define CTF_RIE_HELD_MASK 8'hC3
`define CTF_NUM_BUF 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CTF_RST_TX_FLAGS 3'h7
`define CTF_RST_TX_IE 3'h0
`define CTF_RST_RX_IE 8'h00
`define CTF_RST_CONTROL 3'h0

`endif

// File: core/ctf_pkg.sv
// Types shared by the transmit flag block
// Assumes the defines header is compiled alongside
package ctf_pkg;

   // ------------------------------------------------------------
   // Receiver and transmitter state codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CTF_ST_OK = 2'h0,
      CTF_ST_WARN = 2'h1,
      CTF_ST_ERR = 2'h2,
      CTF_ST_BUS_OFF = 2'h3
   } ctf_bus_state_e;

   // ------------------------------------------------------------
   // Events from the protocol engine, one clock wide
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] tx_done;
      logic [2:0] abort_done;
      logic rx_full;
      logic overrun;
   } ctf_evt_s;

   // Engine fault states, levels on the same clock
   typedef struct packed {
      ctf_bus_state_e tx_state;
      ctf_bus_state_e rx_state;
   } ctf_engine_state_s;

endpackage : ctf_pkg

// File: core/ctf_tx_slot.sv
// One transmit buffer: empty flag, abort request and abort acknowledge
// Assumes all inputs come from logic on the same clock
`timescale 1ns/10ps
module ctf_tx_slot (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Initialization hold
   input wire logic hold,
   // Software actions
   input wire logic sw_clear_empty,
   input wire logic sw_set_abort,
   // Engine events
   input wire logic sent_ok,
   input wire logic abort_granted,
   // State
   output logic empty_reg,
   output logic abort_req_reg,
   output logic abort_ack_reg
);

   logic set_empty;

   // Buffer freed by a good send or an honoured abort
   assign set_empty = sent_ok | abort_granted;

   // Empty flag, set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset || (ce && hold)) begin
         empty_reg <= 1'b1;
      end else if (ce) begin
         if (set_empty) begin
            empty_reg <= 1'b1;
         end else if (sw_clear_empty) begin
            empty_reg <= 1'b0;
         end
      end
   end

   // Abort request, only dropped when the buffer becomes empty
   always_ff @(posedge clk) begin
      if (reset || (ce && hold)) begin
         abort_req_reg <= 1'b0;
      end else if (ce) begin
         if (set_empty) begin
            abort_req_reg <= 1'b0;
         end else if (sw_set_abort && !empty_reg) begin
            abort_req_reg <= 1'b1;
         end
      end
   end

   // Abort acknowledge, dropped when software reschedules the buffer
   always_ff @(posedge clk) begin
      if (reset || (ce && hold)) begin
         abort_ack_reg <= 1'b0;
      end else if (ce) begin
         if (abort_granted) begin
            abort_ack_reg <= 1'b1;
         end else if (sw_clear_empty) begin
            abort_ack_reg <= 1'b0;
         end
      end
   end

endmodule : ctf_tx_slot

// File: core/ctf_tx_flags.sv
// Transmit buffer flags, interrupt enables and receiver interrupt gating
// Assumes engine events and states arrive on CLK, registers on a plain port
//
// Summary of operation
// - Overrun raises error request when enabled
// - Receive full raises receiver request when enabled
// - Bus-off receiver code, forced OK after recovery
// - Write one clears empty flag, zero ignored
// - Flag register held reset during initialization
// - Three empty flags, one means empty
// - Successful send sets the empty flag
// - Honoured abort sets the empty flag
// - Transmit request pending while empty flag clear, unmasked
// - Clearing empty flag clears abort acknowledge
// - Setting empty flag clears abort request
// - Listen mode ignores clears, starts nothing
// - Scheduled buffer contents blocked from access
// - Enable bits gate transmitter empty requests
// - Enable register held reset during initialization
// - Receive full flag set on accepted message
// - Software cannot clear an abort request
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "ctf_defines.svh"
module ctf_tx_flags (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   // Register port
   input wire logic [`CTF_ADDR_W-1:0] ADDR,
   input wire logic [`CTF_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`CTF_DATA_W-1:0] RDATA,
   // Protocol engine side
   input wire ctf_pkg::ctf_evt_s ENGINE_EVT,
   input wire ctf_pkg::ctf_engine_state_s ENGINE_STATE,
   output logic [2:0] TX_REQUEST,
   output logic [2:0] ABORT_REQUEST,
   output logic [2:0] TX_BUF_LOCK,
   output logic LISTEN_MODE,
   output logic INIT_MODE,
   output logic WAKE_ARMED,
   // Interrupt requests
   output logic TX_IRQ,
   output logic RX_IRQ,
   output logic ERR_IRQ
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic init_request_reg;
   logic init_acknowledge_reg;
   logic listen_reg;
   logic wake_function_en_reg;
   logic [`CTF_DATA_W-1:0] rx_interrupt_enables_reg;
   logic [2:0] tx_empty_irq_en_reg;
   logic rx_buffer_full_reg;
   logic overrun_reg;
   ctf_pkg::ctf_bus_state_e receiver_state_reg;
   ctf_pkg::ctf_bus_state_e tx_state_prev_reg;
   ctf_pkg::ctf_bus_state_e receiver_state_next;
   logic [2:0] tx_buffer_empty;
   logic [2:0] abort_request;
   logic [2:0] abort_acknowledge;
   logic [2:0] sw_clear_empty;
   logic [2:0] sw_set_abort;
   logic in_init;
   logic writable;
   logic [`CTF_DATA_W-1:0] rdata_next;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------

   // Write strobe aimed at one offset
   function automatic logic wr_hit(input logic wr, input logic [`CTF_ADDR_W-1:0] addr,
                                   input logic [`CTF_ADDR_W-1:0] off);
      wr_hit = wr && (addr == off);
   endfunction : wr_hit

   // ------------------------------------------------------------
   // Initialization mode
   // ------------------------------------------------------------

   // Mode held only when both request and acknowledge are high
   assign in_init = init_request_reg && init_acknowledge_reg;
   // Buffer, abort and enable writes only accepted when both are low
   assign writable = !init_request_reg && !init_acknowledge_reg;

   // Control bits written by software
   always_ff @(posedge CLK) begin
      if (RESET) begin
         init_request_reg <= 1'b0;
         listen_reg <= 1'b0;
         wake_function_en_reg <= 1'b0;
      end else if (CE && wr_hit(WR, ADDR, `CTF_OFF_CONTROL)) begin
         init_request_reg <= WDATA[`CTF_CTL_INIT_REQ];
         listen_reg <= WDATA[`CTF_CTL_LISTEN];
         wake_function_en_reg <= WDATA[`CTF_CTL_WAKE_FN];
      end
   end

   // Acknowledge follows the request one cycle later
   always_ff @(posedge CLK) begin
      if (RESET) begin
         init_acknowledge_reg <= 1'b0;
      end else if (CE) begin
         init_acknowledge_reg <= init_request_reg;
      end
   end

   // ------------------------------------------------------------
   // Receiver side
   // ------------------------------------------------------------

   // Receiver enables, status change fields kept through initialization
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rx_interrupt_enables_reg <= `CTF_RST_RX_IE;
      end else if (CE) begin
         if (in_init) begin
            rx_interrupt_enables_reg <= rx_interrupt_enables_reg & ~`CTF_RIE_HELD_MASK;
         end else if (writable && wr_hit(WR, ADDR, `CTF_OFF_RX_IE)) begin
            rx_interrupt_enables_reg <= WDATA;
         end
      end
   end

   // Receive full flag, set by the engine wins over a write-one clear
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rx_buffer_full_reg <= 1'b0;
      end else if (CE) begin
         if (ENGINE_EVT.rx_full) begin
            rx_buffer_full_reg <= 1'b1;
         end else if (wr_hit(WR, ADDR, `CTF_OFF_RX_FLAGS) && WDATA[`CTF_RXF_FULL]) begin
            rx_buffer_full_reg <= 1'b0;
         end
      end
   end

   // Overrun flag, same set-over-clear priority
   always_ff @(posedge CLK) begin
      if (RESET) begin
         overrun_reg <= 1'b0;
      end else if (CE) begin
         if (ENGINE_EVT.overrun) begin
            overrun_reg <= 1'b1;
         end else if (wr_hit(WR, ADDR, `CTF_OFF_RX_FLAGS) && WDATA[`CTF_RXF_OVERRUN]) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // Receiver state with extra bus-off code and forced recovery
   always_comb begin
      receiver_state_next = ENGINE_STATE.rx_state;
      if (ENGINE_STATE.tx_state == ctf_pkg::CTF_ST_BUS_OFF) begin
         receiver_state_next = ctf_pkg::CTF_ST_BUS_OFF;
      end else if (tx_state_prev_reg == ctf_pkg::CTF_ST_BUS_OFF &&
                   ENGINE_STATE.tx_state == ctf_pkg::CTF_ST_OK) begin
         receiver_state_next = ctf_pkg::CTF_ST_OK;
      end
   end

   // State tracking, unaffected by initialization
   always_ff @(posedge CLK) begin
      if (RESET) begin
         receiver_state_reg <= ctf_pkg::CTF_ST_OK;
         tx_state_prev_reg <= ctf_pkg::CTF_ST_OK;
      end else if (CE) begin
         receiver_state_reg <= receiver_state_next;
         tx_state_prev_reg <= ENGINE_STATE.tx_state;
      end
   end

   // ------------------------------------------------------------
   // Transmit buffers
   // ------------------------------------------------------------

   // Per-buffer software actions and flag cells
   genvar gi;
   generate
      for (gi = 0; gi < `CTF_NUM_BUF; gi = gi + 1) begin : g_slot
         // Clear request honoured only when writable and not listening
         assign sw_clear_empty[gi] = writable && !listen_reg && WDATA[gi] &&
                                     wr_hit(WR, ADDR, `CTF_OFF_TX_FLAGS);
         // Abort request only ever set by software
         assign sw_set_abort[gi] = writable && WDATA[gi] &&
                                   wr_hit(WR, ADDR, `CTF_OFF_ABORT_REQ);

         ctf_tx_slot u_slot (
            .clk(CLK),
            .reset(RESET),
            .ce(CE),
            .hold(in_init),
            .sw_clear_empty(sw_clear_empty[gi]),
            .sw_set_abort(sw_set_abort[gi]),
            .sent_ok(ENGINE_EVT.tx_done[gi]),
            .abort_granted(ENGINE_EVT.abort_done[gi]),
            .empty_reg(tx_buffer_empty[gi]),
            .abort_req_reg(abort_request[gi]),
            .abort_ack_reg(abort_acknowledge[gi])
         );
      end
   endgenerate

   // Transmitter empty interrupt enables
   always_ff @(posedge CLK) begin
      if (RESET) begin
         tx_empty_irq_en_reg <= `CTF_RST_TX_IE;
      end else if (CE) begin
         if (in_init) begin
            tx_empty_irq_en_reg <= `CTF_RST_TX_IE;
         end else if (writable && wr_hit(WR, ADDR, `CTF_OFF_TX_IE)) begin
            tx_empty_irq_en_reg <= WDATA[2:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Engine-facing outputs
   // ------------------------------------------------------------

   // Scheduled buffers offered to the engine, none in listen mode
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TX_REQUEST <= 3'h0;
         TX_BUF_LOCK <= 3'h0;
         ABORT_REQUEST <= 3'h0;
      end else if (CE) begin
         TX_REQUEST <= (listen_reg || in_init) ? 3'h0 : ~tx_buffer_empty;
         TX_BUF_LOCK <= ~tx_buffer_empty;
         ABORT_REQUEST <= abort_request;
      end
   end

   // Mode indications
   always_ff @(posedge CLK) begin
      if (RESET) begin
         LISTEN_MODE <= 1'b0;
         INIT_MODE <= 1'b0;
         WAKE_ARMED <= 1'b0;
      end else if (CE) begin
         LISTEN_MODE <= listen_reg;
         INIT_MODE <= in_init;
         WAKE_ARMED <= wake_function_en_reg && rx_interrupt_enables_reg[`CTF_RIE_WAKE];
      end
   end

   // ------------------------------------------------------------
   // Interrupt requests
   // ------------------------------------------------------------

   // Level requests, pending while flag set and enabled
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TX_IRQ <= 1'b0;
         RX_IRQ <= 1'b0;
         ERR_IRQ <= 1'b0;
      end else if (CE) begin
         TX_IRQ <= |(tx_buffer_empty & tx_empty_irq_en_reg);
         RX_IRQ <= rx_buffer_full_reg && rx_interrupt_enables_reg[`CTF_RIE_RX_FULL];
         ERR_IRQ <= overrun_reg && rx_interrupt_enables_reg[`CTF_RIE_OVERRUN];
      end
   end

   // ------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------

   // Read mux, unmapped offsets return zero
   always_comb begin
      rdata_next = '0;
      case (ADDR)
         `CTF_OFF_CONTROL: begin
            rdata_next[`CTF_CTL_INIT_REQ] = init_request_reg;
            rdata_next[`CTF_CTL_LISTEN] = listen_reg;
            rdata_next[`CTF_CTL_WAKE_FN] = wake_function_en_reg;
            rdata_next[`CTF_CTL_INIT_ACK] = init_acknowledge_reg;
         end
         `CTF_OFF_RX_FLAGS: begin
            rdata_next[`CTF_RXF_FULL] = rx_buffer_full_reg;
            rdata_next[`CTF_RXF_OVERRUN] = overrun_reg;
            rdata_next[`CTF_RXF_STATE_LO +: 2] = receiver_state_reg;
         end
         `CTF_OFF_RX_IE: begin
            rdata_next = rx_interrupt_enables_reg;
         end
         `CTF_OFF_TX_FLAGS: begin
            rdata_next[2:0] = tx_buffer_empty;
         end
         `CTF_OFF_TX_IE: begin
            rdata_next[2:0] = tx_empty_irq_en_reg;
         end
         `CTF_OFF_ABORT_REQ: begin
            rdata_next[2:0] = abort_request;
         end
         `CTF_OFF_ABORT_ACK: begin
            rdata_next[2:0] = abort_acknowledge;
         end
         default: begin
            rdata_next = '0;
         end
      endcase
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RDATA <= '0;
      end else if (CE) begin
         RDATA <= RD ? rdata_next : '0;
      end
   end

endmodule : ctf_tx_flags

// File: test/ctf_tx_flags_assertions.sv
// Port checks for the transmit flag block
// Assumes one clock domain, bound onto the block top
`timescale 1ns/10ps
`include "ctf_defines.svh"
module ctf_tx_flags_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Register port
   input wire logic [`CTF_ADDR_W-1:0] ADDR,
   input wire logic WR,
   // Engine side
   input wire ctf_pkg::ctf_evt_s ENGINE_EVT,
   input wire logic [2:0] TX_REQUEST,
   input wire logic [2:0] ABORT_REQUEST,
   input wire logic [2:0] TX_BUF_LOCK,
   input wire logic LISTEN_MODE,
   input wire logic INIT_MODE,
   // Interrupts
   input wire logic TX_IRQ,
   input wire logic RX_IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   // ------------------------------------------------------------
   // Buffer state relations
   // ------------------------------------------------------------
   property p_irq_or;
      TX_IRQ |-> TX_BUF_LOCK != 3'h7;
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("tx irq with no empty buffer");
   property p_req_lock;
      (TX_REQUEST & ~TX_BUF_LOCK) == 3'h0;
   endproperty
   a_req_lock: assert property (p_req_lock) else $error("request on unlocked buffer");
   property p_listen;
      LISTEN_MODE |-> TX_REQUEST == 3'h0;
   endproperty
   a_listen: assert property (p_listen) else $error("request in listen mode");
   property p_init;
      INIT_MODE && $past(INIT_MODE) |-> TX_BUF_LOCK == 3'h0 && ABORT_REQUEST == 3'h0 && !TX_IRQ;
   endproperty
   a_init: assert property (p_init) else $error("flags not held in init");
   property p_abort_lock;
      (ABORT_REQUEST & ~TX_BUF_LOCK) == 3'h0;
   endproperty
   a_abort_lock: assert property (p_abort_lock) else $error("abort kept on empty buffer");

   // ------------------------------------------------------------
   // Event timing
   // ------------------------------------------------------------
   property p_evt_unlock;
      (ENGINE_EVT.tx_done | ENGINE_EVT.abort_done) != 3'h0 |->
         ##2 (TX_BUF_LOCK & $past(ENGINE_EVT.tx_done | ENGINE_EVT.abort_done, 2)) == 3'h0;
   endproperty
   a_evt_unlock: assert property (p_evt_unlock) else $error("buffer not freed");
   property p_tx_rise;
      $rose(TX_IRQ) |-> $past(ENGINE_EVT.tx_done | ENGINE_EVT.abort_done, 2) != 3'h0
         || ($past(WR, 2) && $past(ADDR, 2) == 8'h07);
   endproperty
   a_tx_rise: assert property (p_tx_rise) else $error("tx irq rose without cause");
   property p_rx_rise;
      $rose(RX_IRQ) |-> $past(ENGINE_EVT.rx_full, 2) || ($past(WR, 2) && $past(ADDR, 2) == 8'h05);
   endproperty
   a_rx_rise: assert property (p_rx_rise) else $error("rx irq rose without cause");
endmodule : ctf_tx_flags_assertions

bind ctf_tx_flags ctf_tx_flags_assertions ctf_tx_flags_assertions_inst (.CLK, .RESET, .ADDR, .WR,
   .ENGINE_EVT, .TX_REQUEST, .ABORT_REQUEST, .TX_BUF_LOCK, .LISTEN_MODE, .INIT_MODE, .TX_IRQ, .RX_IRQ);

// File: test/ctf_engine_model.sv
// Remote bus model: finishes or aborts a frame after a latency
// Assumes commands from the bench on the same clock
`timescale 1ns/10ps
module ctf_engine_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Design state
   input wire logic [2:0] tx_req,
   input wire logic [2:0] abort_req,
   // Bench commands
   input wire logic go,
   input wire logic [1:0] idx,
   input wire logic [3:0] lat,
   input wire logic rx_p,
   input wire logic ov_p,
   // Events to the design
   output ctf_pkg::ctf_evt_s evt
);
   int cnt;
   logic [1:0] sel;
   logic [2:0] tx_d;
   logic [2:0] ab_d;
   // Count the latency, then abort if asked, else send
   always @(posedge clk) begin
      tx_d <= 3'h0;
      ab_d <= 3'h0;
      if (reset) begin
         cnt <= 0;
      end else if (go) begin
         cnt <= lat + 1;
         sel <= idx;
      end else if (cnt == 1) begin
         cnt <= 0;
         if (abort_req[sel]) begin
            ab_d[sel] <= 1'b1;
         end else if (tx_req[sel]) begin
            tx_d[sel] <= 1'b1;
         end
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
   assign evt = {tx_d, ab_d, rx_p, ov_p};
endmodule : ctf_engine_model

// File: test/ctf_tx_flags_tb.sv
// Self-checking bench for the transmit flag block
// Assumes design, engine model and checker compiled first
`timescale 1ns/10ps
module ctf_tx_flags_tb;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic go = 1'b0;
   logic [1:0] idx = 2'h0;
   logic [3:0] lat = 4'h0;
   logic rx_p = 1'b0;
   logic ov_p = 1'b0;
   ctf_pkg::ctf_engine_state_s est = 4'h0;
   ctf_pkg::ctf_evt_s evt;
   logic [7:0] rdata;
   logic [2:0] txr, abr, lck;
   logic lst, inm, wak, tirq, rirq, eirq;
   int err_total = 0;
   int checks_done = 0;
   int m_e = 7, m_ie = 0, m_rq = 0, m_ak = 0, m_lst = 0, m_rf = 0, m_of = 0, m_rie = 0;
   logic [31:0] seed = 32'h6A2F;
   int k;

   // Clock of 100 ns
   always #50 CLK = ~CLK;

   ctf_tx_flags ctf_tx_flags_inst (.CLK(CLK), .RESET(RESET), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(rdata), .ENGINE_EVT(evt), .ENGINE_STATE(est), .TX_REQUEST(txr),
      .ABORT_REQUEST(abr), .TX_BUF_LOCK(lck), .LISTEN_MODE(lst), .INIT_MODE(inm), .WAKE_ARMED(wak),
      .TX_IRQ(tirq), .RX_IRQ(rirq), .ERR_IRQ(eirq));
   ctf_engine_model ctf_engine_model_inst (.clk(CLK), .reset(RESET), .tx_req(txr), .abort_req(abr),
      .go(go), .idx(idx), .lat(lat), .rx_p(rx_p), .ov_p(ov_p), .evt(evt));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input string n, input int e, input logic [7:0] g);
      checks_done++;
      if (g !== 8'(e)) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, 8'(e), g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input int e, input string n);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(n, e, rdata);
   endtask : rd

   task automatic outs();
      repeat (2) @(posedge CLK);
      #1;
      chk("tx_irq", (m_e & m_ie) != 0, {7'h0, tirq});
      chk("tx_req", m_lst ? 0 : ~m_e & 7, {5'h0, txr});
      chk("lock", ~m_e & 7, {5'h0, lck});
      chk("abort", m_rq, {5'h0, abr});
      chk("rx_irq", m_rf & m_rie, {7'h0, rirq});
      chk("err_irq", m_of & (m_rie >> 1), {7'h0, eirq});
      chk("listen", m_lst, {7'h0, lst});
      chk("init_mode", 0, {7'h0, inm});
   endtask : outs

   task automatic fin(input int i, input int l);
      @(posedge CLK);
      go <= 1'b1;
      idx <= 2'(i);
      lat <= 4'(l);
      @(posedge CLK);
      go <= 1'b0;
      repeat (l + 4) @(posedge CLK);
      if (m_rq & (1 << i)) begin
         m_rq &= ~(1 << i);
         m_ak |= 1 << i;
      end
      if (!m_lst) m_e |= 1 << i;
      outs();
   endtask : fin

   task automatic ev(input logic r, input logic o);
      @(posedge CLK);
      rx_p <= r;
      ov_p <= o;
      @(posedge CLK);
      rx_p <= 1'b0;
      ov_p <= 1'b0;
      m_rf |= r;
      m_of |= o;
      outs();
   endtask : ev

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      rd(8'h06, 7, "flags");
      rd(8'h07, 0, "tx_ie");
      rd(8'h3C, 0, "unmapped");
      wr(8'h07, 8'h07);
      m_ie = 7;
      outs();
      // Random schedules, then frames sent
      for (k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         wr(8'h06, seed[7:0]);
         m_e &= ~seed[2:0];
         rd(8'h06, m_e, "flags");
         outs();
         fin(k % 3, seed[11:8]);
      end
      // Abort a scheduled buffer
      wr(8'h06, 8'h02);
      m_e &= 5;
      wr(8'h08, 8'h03);
      m_rq = 3 & ~m_e;
      wr(8'h08, 8'h00);
      rd(8'h08, m_rq, "abort_req");
      fin(1, 2);
      rd(8'h09, m_ak, "abort_ack");
      wr(8'h06, 8'h02);
      m_e &= 5;
      m_ak &= 5;
      rd(8'h09, m_ak, "abort_ack");
      for (k = 0; k < 3; k++) fin(k, k * 7);
      // Listen mode ignores clears
      wr(8'h00, 8'h02);
      m_lst = 1;
      wr(8'h06, 8'h07);
      rd(8'h06, m_e, "flags");
      outs();
      wr(8'h00, 8'h00);
      m_lst = 0;
      // Init mode with a buffer scheduled
      wr(8'h06, 8'h04);
      wr(8'h00, 8'h01);
      repeat (4) @(posedge CLK);
      #1;
      chk("init_mode", 1, {7'h0, inm});
      wr(8'h07, 8'h07);
      rd(8'h06, 7, "flags");
      rd(8'h07, 0, "tx_ie");
      wr(8'h00, 8'h00);
      repeat (3) @(posedge CLK);
      m_e = 7;
      m_ie = 0;
      m_rq = 0;
      m_ak = 0;
      wr(8'h07, 8'h05);
      m_ie = 5;
      outs();
      // Receiver requests
      wr(8'h05, 8'h03);
      m_rie = 3;
      ev(1'b1, 1'b0);
      wr(8'h04, 8'h01);
      m_rf = 0;
      wr(8'h05, 8'h00);
      m_rie = 0;
      ev(1'b1, 1'b1);
      wr(8'h05, 8'h02);
      m_rie = 2;
      outs();
      wr(8'h04, 8'h03);
      m_rf = 0;
      m_of = 0;
      // Receiver state follows transmitter bus-off
      est <= {ctf_pkg::CTF_ST_BUS_OFF, ctf_pkg::CTF_ST_WARN};
      rd(8'h04, 8'h30, "rx_state");
      // Engine still reports a warning receiver; recovery must force OK
      est <= {ctf_pkg::CTF_ST_OK, ctf_pkg::CTF_ST_WARN};
      rd(8'h04, 0, "rx_state");
      // Wake path armed by both enables
      wr(8'h00, 8'h04);
      wr(8'h05, 8'h80);
      repeat (2) @(posedge CLK);
      #1;
      chk("wake", 1, {7'h0, wak});
      wrap_up();
   end

   // Watchdog against a hang
   initial begin
      repeat (4000) @(posedge CLK);
      err_total++;
      wrap_up();
   end
endmodule : ctf_tx_flags_tb
